// [logic/ddrl_defs.svh]
// ddrl_defs.svh: numeric constants of the ddr read latency link and query table.
// assumes it is included by bare name from the package and both link ends.
`ifndef DDRL_DEFS_SVH
`define DDRL_DEFS_SVH

// ddr read instructions, 3-byte and 4-byte address forms
`define DDRL_OP_FAST_3B 8'h0d
`define DDRL_OP_FAST_4B 8'h0e
`define DDRL_OP_DUAL_3B 8'hbd
`define DDRL_OP_DUAL_4B 8'hbe
`define DDRL_OP_QUAD_3B 8'hed
`define DDRL_OP_QUAD_4B 8'hee

// mode cycles per read kind, the same for every latency code
`define DDRL_MODE_FAST 8'h00
`define DDRL_MODE_DUAL 8'h00
`define DDRL_MODE_QUAD 8'h01

// latency cycles per latency code and read kind
`define DDRL_LAT_C11_FAST 8'h04
`define DDRL_LAT_C11_DUAL 8'h04
`define DDRL_LAT_C11_QUAD 8'h03
`define DDRL_LAT_C00_FAST 8'h05
`define DDRL_LAT_C00_DUAL 8'h06
`define DDRL_LAT_C00_QUAD 8'h06
`define DDRL_LAT_C01_FAST 8'h06
`define DDRL_LAT_C01_DUAL 8'h07
`define DDRL_LAT_C01_QUAD 8'h07
`define DDRL_LAT_C10_FAST 8'h07
`define DDRL_LAT_C10_DUAL 8'h08
`define DDRL_LAT_C10_QUAD 8'h08

// serial clock ceilings in mhz, as the table byte encodes them
`define DDRL_FMAX_C11 8'h32
`define DDRL_FMAX_C00 8'h42
`define DDRL_FMAX_C01 8'h42
`define DDRL_FMAX_C10 8'h42

// query table layout
`define DDRL_Q_ID 8'h9a
`define DDRL_Q_LEN 8'h2a
`define DDRL_Q_ROWS 8'h05
`define DDRL_Q_ROW_LEN 8'h08
`define DDRL_Q_HDR_F 8'h46
`define DDRL_Q_HDR_C 8'h43
`define DDRL_Q_OFF_ID 6'h00
`define DDRL_Q_OFF_LEN 6'h01
`define DDRL_Q_OFF_ROWS 6'h02
`define DDRL_Q_OFF_ROW_LEN 6'h03
`define DDRL_Q_OFF_HDR_F 6'h04
`define DDRL_Q_OFF_HDR_C 6'h05
`define DDRL_Q_OFF_OPS 6'h06
`define DDRL_Q_OFF_ROW2 6'h0c
`define DDRL_Q_OFF_END 6'h2c

// byte the host drives in each mode cycle: no continuous read
`define DDRL_MODE_BYTE 8'h00
// default host serial clock rate in mhz
`define DDRL_HOST_SCK_MHZ 8'h32

`endif

// [logic/ddrl_dev.sv]
// ddrl_dev: flash end of the ddr read link, with the ddr latency query table.
// assumes a combinational array on mem_addr/mem_data and a host sharing core_clk.
// the latency code is taken with the opcode, so it may change between frames.
// Behaviour
// RULE1: code 11b: fast/dual 0+4, quad 1+3
// RULE2: code 00b: fast 0+5, dual 0+6, quad 1+6
// RULE3: code 01b: fast 0+6, dual 0+7, quad 1+7
// RULE4: code 10b: fast 0+7, dual 0+8, quad 1+8
// RULE5: host keeps sck at 66 MHz, code 00b
// RULE6: 66 MHz ceiling also for codes 01b, 10b
// RULE7: table rows: limit, code, then mode/latency pairs
// RULE8: host keeps sck at 50 MHz, code 11b
// RULE9: table id 9Ah, length, five rows of eight
// RULE10: opcodes 0D/0E, BD/BE, ED/EE per address width
// RULE11: mode, then latency, data on following edge
`timescale 1ns/1ps
`include "ddrl_defs.svh"

module ddrl_dev (
  input wire logic core_clk,
  input wire logic rstn,
  ddrl_if.dev link,
  input wire logic [1:0] lat_code,
  output logic [31:0] mem_addr,
  input wire logic [7:0] mem_data,
  output logic frame_err
);

  // frame sequencer state
  ddrl_pkg::ddrl_state_t state_reg;
  ddrl_pkg::ddrl_kind_t kind_reg;
  logic [1:0] code_reg;
  logic [7:0] cnt_reg;
  logic [7:0] op_byte;
  logic [31:0] addr_reg;

  // registered link and pin outputs
  logic [7:0] dev_dq_reg;
  logic dev_oe_reg;
  logic q_ack_reg;
  logic [7:0] q_data_reg;
  logic [31:0] mem_addr_reg;
  logic frame_err_reg;

  // query table decode
  logic [5:0] row_off;
  logic [1:0] row_code;
  ddrl_pkg::ddrl_kind_t col_kind;
  logic [7:0] q_byte;

  assign op_byte = link.host_dq;

  // query table byte at the requested offset
  // offsets 0c..2b are four rows of eight bytes: ceiling, code, then
  // one mode/latency pair per read kind in fast, dual, quad order
  always_comb begin
    row_off = link.q_off - `DDRL_Q_OFF_ROW2;
    // rows hold codes 11b, 00b, 01b, 10b in turn
    row_code = 2'(row_off[4:3] + 2'b11); // [RULE7]
    // shift before narrowing, or positions 6 and 7 would fold onto fast
    col_kind = ddrl_pkg::ddrl_kind_t'(2'((row_off[2:0] - 3'd2) >> 1));
    q_byte = 8'h00;
    if (link.q_off >= `DDRL_Q_OFF_END) begin
      q_byte = 8'h00; // past the parameter end
    end else if (link.q_off >= `DDRL_Q_OFF_ROW2) begin
      unique case (row_off[2:0])
        3'd0: q_byte = ddrl_pkg::fmax(row_code); // [RULE5] [RULE6] [RULE8]
        3'd1: q_byte = {6'h00, row_code}; // [RULE7]
        3'd2, 3'd4, 3'd6: q_byte = ddrl_pkg::mode_cnt(col_kind); // [RULE7]
        default: q_byte = ddrl_pkg::lat_cnt(col_kind, row_code); // [RULE7]
      endcase
    end else begin
      // header: id, length, row count and size, column tags, opcodes
      unique case (link.q_off)
        `DDRL_Q_OFF_ID: q_byte = `DDRL_Q_ID; // [RULE9]
        `DDRL_Q_OFF_LEN: q_byte = `DDRL_Q_LEN; // [RULE9]
        `DDRL_Q_OFF_ROWS: q_byte = `DDRL_Q_ROWS; // [RULE9]
        `DDRL_Q_OFF_ROW_LEN: q_byte = `DDRL_Q_ROW_LEN; // [RULE9]
        `DDRL_Q_OFF_HDR_F: q_byte = `DDRL_Q_HDR_F;
        `DDRL_Q_OFF_HDR_C: q_byte = `DDRL_Q_HDR_C;
        6'h06: q_byte = `DDRL_OP_FAST_3B; // [RULE10]
        6'h07: q_byte = `DDRL_OP_FAST_4B; // [RULE10]
        6'h08: q_byte = `DDRL_OP_DUAL_3B; // [RULE10]
        6'h09: q_byte = `DDRL_OP_DUAL_4B; // [RULE10]
        6'h0a: q_byte = `DDRL_OP_QUAD_3B; // [RULE10]
        default: q_byte = `DDRL_OP_QUAD_4B; // [RULE10]
      endcase
    end
  end

  // query answer one cycle after the request
  // data holds between answers; only the ack is a pulse
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q_ack_reg <= 1'b0;
      q_data_reg <= 8'h00;
    end else begin
      q_ack_reg <= link.q_req;
      if (link.q_req) begin
        q_data_reg <= q_byte;
      end
    end
  end

  // frame sequencer: opcode, address, mode, latency, data
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= ddrl_pkg::DDRL_ST_IDLE;
      kind_reg <= ddrl_pkg::DDRL_KIND_NONE;
      code_reg <= 2'b00;
      cnt_reg <= 8'h00;
      addr_reg <= 32'h0000_0000;
    end else if (!link.cs) begin
      // a frame ends wherever cs drops, even mid-sequence
      state_reg <= ddrl_pkg::DDRL_ST_IDLE;
    end else begin
      unique case (state_reg)
        // opcode byte: read kind, address width and latency code
        ddrl_pkg::DDRL_ST_IDLE: begin
          kind_reg <= ddrl_pkg::kind_of(op_byte); // [RULE10]
          cnt_reg <= ddrl_pkg::addr_bytes(op_byte); // [RULE10]
          code_reg <= lat_code;
          addr_reg <= 32'h0000_0000;
          if (ddrl_pkg::kind_of(op_byte) == ddrl_pkg::DDRL_KIND_NONE) begin
            state_reg <= ddrl_pkg::DDRL_ST_SKIP;
          end else begin
            state_reg <= ddrl_pkg::DDRL_ST_ADDR;
          end
        end
        // address bytes, most significant first
        ddrl_pkg::DDRL_ST_ADDR: begin
          addr_reg <= {addr_reg[23:0], link.host_dq};
          cnt_reg <= 8'(cnt_reg - 8'h01);
          if (cnt_reg == 8'h01) begin
            if (ddrl_pkg::mode_cnt(kind_reg) != 8'h00) begin // [RULE11]
              state_reg <= ddrl_pkg::DDRL_ST_MODE;
              cnt_reg <= ddrl_pkg::mode_cnt(kind_reg); // [RULE1] [RULE2] [RULE3] [RULE4]
            end else begin
              state_reg <= ddrl_pkg::DDRL_ST_LAT;
              cnt_reg <= ddrl_pkg::lat_cnt(kind_reg, code_reg); // [RULE1] [RULE2]
            end
          end
        end
        // mode cycles, only the quad read has one
        ddrl_pkg::DDRL_ST_MODE: begin
          cnt_reg <= 8'(cnt_reg - 8'h01);
          if (cnt_reg == 8'h01) begin
            state_reg <= ddrl_pkg::DDRL_ST_LAT; // [RULE11]
            cnt_reg <= ddrl_pkg::lat_cnt(kind_reg, code_reg); // [RULE3] [RULE4]
          end
        end
        // latency: the host has released the lines
        ddrl_pkg::DDRL_ST_LAT: begin
          cnt_reg <= 8'(cnt_reg - 8'h01);
          if (cnt_reg == 8'h01) begin
            state_reg <= ddrl_pkg::DDRL_ST_DATA; // [RULE11]
          end
        end
        // data runs until cs drops
        ddrl_pkg::DDRL_ST_DATA: state_reg <= ddrl_pkg::DDRL_ST_DATA;
        // refused opcode: the rest of the frame is ignored
        ddrl_pkg::DDRL_ST_SKIP: state_reg <= ddrl_pkg::DDRL_ST_SKIP;
        default: state_reg <= ddrl_pkg::DDRL_ST_SKIP;
      endcase
    end
  end

  // data drive: first byte launched at the edge ending the last latency cycle
  // cs fall is seen one edge late, so one byte overhangs the frame
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dev_dq_reg <= 8'h00;
      dev_oe_reg <= 1'b0;
      mem_addr_reg <= 32'h0000_0000;
    end else begin
      // the address is complete with its last byte: load the memory pointer
      if (link.cs && state_reg == ddrl_pkg::DDRL_ST_ADDR && cnt_reg == 8'h01) begin
        mem_addr_reg <= {addr_reg[23:0], link.host_dq};
      end
      if (link.cs && ((state_reg == ddrl_pkg::DDRL_ST_LAT && cnt_reg == 8'h01) ||
                      state_reg == ddrl_pkg::DDRL_ST_DATA)) begin
        dev_dq_reg <= mem_data; // [RULE11]
        dev_oe_reg <= 1'b1;
        mem_addr_reg <= 32'(mem_addr_reg + 32'h0000_0001);
      end else begin
        dev_oe_reg <= 1'b0;
      end
    end
  end

  // unknown opcode flag, one cycle per refused frame
  // the refused frame then sits in skip until cs drops
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      frame_err_reg <= 1'b0;
    end else begin
      frame_err_reg <= link.cs && state_reg == ddrl_pkg::DDRL_ST_IDLE &&
                       ddrl_pkg::kind_of(op_byte) == ddrl_pkg::DDRL_KIND_NONE;
    end
  end

  // every link and pin output straight from its flip-flop
  assign link.dev_dq = dev_dq_reg;
  assign link.dev_oe = dev_oe_reg;
  assign link.q_ack = q_ack_reg;
  assign link.q_data = q_data_reg;
  assign mem_addr = mem_addr_reg;
  assign frame_err = frame_err_reg;

endmodule : ddrl_dev

// [logic/ddrl_host.sv]
// ddrl_host: controller end that issues ddr reads and query-table reads.
// assumes the flash end shares core_clk and holds the same latency code.
`timescale 1ns/1ps
`include "ddrl_defs.svh"

module ddrl_host #(
  parameter logic [7:0] SCK_MHZ = `DDRL_HOST_SCK_MHZ
) (
  input wire logic core_clk,
  input wire logic rstn,
  ddrl_if.host link,
  input wire logic [1:0] lat_code,
  input wire logic rd_start,
  input wire logic [7:0] rd_op,
  input wire logic [31:0] rd_addr,
  input wire logic [7:0] rd_len,
  output logic busy,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic done,
  output logic err,
  input wire logic q_start,
  input wire logic [5:0] q_off,
  output logic [7:0] q_data,
  output logic q_valid
);

  ddrl_pkg::ddrl_state_t state_reg;
  ddrl_pkg::ddrl_kind_t kind_reg;
  ddrl_pkg::ddrl_kind_t start_kind;
  logic [7:0] cnt_reg;
  logic [7:0] len_reg;
  logic [31:0] sh_reg;
  logic cs_reg, oe_reg, done_reg, err_reg, rx_valid_reg, q_req_reg, q_valid_reg;
  logic [7:0] dq_reg, rx_data_reg, q_data_reg;
  logic [5:0] q_off_reg;
  logic refuse;

  assign start_kind = ddrl_pkg::kind_of(rd_op);
  // refuse unknown opcodes, zero length, or a clock above the code's ceiling
  assign refuse = start_kind == ddrl_pkg::DDRL_KIND_NONE || rd_len == 8'h00 ||
                  SCK_MHZ > ddrl_pkg::fmax(lat_code); // [RULE5] [RULE6] [RULE8]

  // frame sequencer; counts mirror the flash end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= ddrl_pkg::DDRL_ST_IDLE;
      kind_reg <= ddrl_pkg::DDRL_KIND_NONE;
      cnt_reg <= 8'h00;
      len_reg <= 8'h00;
      sh_reg <= 32'h0000_0000;
      cs_reg <= 1'b0;
      oe_reg <= 1'b0;
      dq_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        ddrl_pkg::DDRL_ST_IDLE: begin
          if (rd_start && !refuse) begin
            cs_reg <= 1'b1;
            oe_reg <= 1'b1;
            dq_reg <= rd_op; // [RULE10]
            kind_reg <= start_kind;
            len_reg <= rd_len;
            cnt_reg <= ddrl_pkg::addr_bytes(rd_op); // [RULE10]
            sh_reg <= rd_op[0] ? {rd_addr[23:0], 8'h00} : rd_addr;
            state_reg <= ddrl_pkg::DDRL_ST_ADDR;
          end
        end
        ddrl_pkg::DDRL_ST_ADDR: begin
          dq_reg <= sh_reg[31:24];
          sh_reg <= {sh_reg[23:0], 8'h00};
          cnt_reg <= 8'(cnt_reg - 8'h01);
          if (cnt_reg == 8'h01) begin
            if (ddrl_pkg::mode_cnt(kind_reg) != 8'h00) begin // [RULE11]
              state_reg <= ddrl_pkg::DDRL_ST_MODE;
              cnt_reg <= ddrl_pkg::mode_cnt(kind_reg); // [RULE1] [RULE2] [RULE3] [RULE4]
            end else begin
              state_reg <= ddrl_pkg::DDRL_ST_LAT;
              // one extra so data state starts with the first data cycle
              cnt_reg <= 8'(ddrl_pkg::lat_cnt(kind_reg, lat_code) + 8'h01); // [RULE1]
            end
          end
        end
        ddrl_pkg::DDRL_ST_MODE: begin
          dq_reg <= `DDRL_MODE_BYTE; // [RULE11]
          cnt_reg <= 8'(cnt_reg - 8'h01);
          if (cnt_reg == 8'h01) begin
            state_reg <= ddrl_pkg::DDRL_ST_LAT;
            cnt_reg <= 8'(ddrl_pkg::lat_cnt(kind_reg, lat_code) + 8'h01); // [RULE2] [RULE3]
          end
        end
        ddrl_pkg::DDRL_ST_LAT: begin
          oe_reg <= 1'b0; // idle through latency [RULE11]
          cnt_reg <= 8'(cnt_reg - 8'h01);
          if (cnt_reg == 8'h01) begin
            state_reg <= ddrl_pkg::DDRL_ST_DATA; // [RULE4]
          end
        end
        ddrl_pkg::DDRL_ST_DATA: begin
          len_reg <= 8'(len_reg - 8'h01);
          if (len_reg == 8'h01) begin
            cs_reg <= 1'b0;
            state_reg <= ddrl_pkg::DDRL_ST_IDLE;
          end
        end
        default: state_reg <= ddrl_pkg::DDRL_ST_IDLE;
      endcase
    end
  end

  // captured data and status pulses
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_data_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      rx_valid_reg <= state_reg == ddrl_pkg::DDRL_ST_DATA; // [RULE11]
      if (state_reg == ddrl_pkg::DDRL_ST_DATA) begin
        rx_data_reg <= link.dev_dq;
      end
      done_reg <= state_reg == ddrl_pkg::DDRL_ST_DATA && len_reg == 8'h01;
      err_reg <= state_reg == ddrl_pkg::DDRL_ST_IDLE && rd_start && refuse;
    end
  end

  // query read: request pulse, answer taken on ack
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q_req_reg <= 1'b0;
      q_off_reg <= 6'h00;
      q_data_reg <= 8'h00;
      q_valid_reg <= 1'b0;
    end else begin
      q_req_reg <= q_start; // [RULE9]
      if (q_start) begin
        q_off_reg <= q_off;
      end
      q_valid_reg <= link.q_ack;
      if (link.q_ack) begin
        q_data_reg <= link.q_data; // [RULE7]
      end
    end
  end

  assign link.cs = cs_reg;
  assign link.host_dq = dq_reg;
  assign link.host_oe = oe_reg;
  assign link.q_req = q_req_reg;
  assign link.q_off = q_off_reg;
  assign busy = cs_reg;
  assign rx_data = rx_data_reg;
  assign rx_valid = rx_valid_reg;
  assign done = done_reg;
  assign err = err_reg;
  assign q_data = q_data_reg;
  assign q_valid = q_valid_reg;

endmodule : ddrl_host

// [logic/ddrl_if.sv]
// ddrl_if: the serial link between the ddr read host and the flash end.
// assumes one shared clock; the bench joins the two ends through it.
`timescale 1ns/1ps

interface ddrl_if;
  logic cs;
  logic [7:0] host_dq;
  logic host_oe;
  logic [7:0] dev_dq;
  logic dev_oe;
  logic q_req;
  logic [5:0] q_off;
  logic q_ack;
  logic [7:0] q_data;
  // resolved data lines, for observation only; released lines read ff like a pulled-up bus
  wire [7:0] dq_bus = dev_oe ? dev_dq : (host_oe ? host_dq : 8'hff);

  modport dev (input cs, input host_dq, input host_oe, output dev_dq, output dev_oe,
               input q_req, input q_off, output q_ack, output q_data);
  modport host (output cs, output host_dq, output host_oe, input dev_dq, input dev_oe,
                output q_req, output q_off, input q_ack, input q_data);
endinterface : ddrl_if

// [logic/ddrl_pkg.sv]
// ddrl_pkg: types and table lookups shared by both ends of the ddr read link.
// assumes ddrl_defs.svh is on the include path.
`include "ddrl_defs.svh"

package ddrl_pkg;

  typedef enum logic [1:0] {
    DDRL_KIND_FAST = 2'b00,
    DDRL_KIND_DUAL = 2'b01,
    DDRL_KIND_QUAD = 2'b10,
    DDRL_KIND_NONE = 2'b11
  } ddrl_kind_t;

  typedef enum logic [2:0] {
    DDRL_ST_IDLE = 3'b000,
    DDRL_ST_ADDR = 3'b001,
    DDRL_ST_MODE = 3'b010,
    DDRL_ST_LAT = 3'b011,
    DDRL_ST_DATA = 3'b100,
    DDRL_ST_SKIP = 3'b101
  } ddrl_state_t;

  // read kind from the instruction byte
  function automatic ddrl_kind_t kind_of(input logic [7:0] op);
    case (op)
      `DDRL_OP_FAST_3B, `DDRL_OP_FAST_4B: kind_of = DDRL_KIND_FAST;
      `DDRL_OP_DUAL_3B, `DDRL_OP_DUAL_4B: kind_of = DDRL_KIND_DUAL;
      `DDRL_OP_QUAD_3B, `DDRL_OP_QUAD_4B: kind_of = DDRL_KIND_QUAD;
      default: kind_of = DDRL_KIND_NONE;
    endcase
  endfunction : kind_of

  // the 4-byte forms all have an even instruction code
  function automatic logic [7:0] addr_bytes(input logic [7:0] op);
    addr_bytes = op[0] ? 8'h03 : 8'h04;
  endfunction : addr_bytes

  function automatic logic [7:0] mode_cnt(input ddrl_kind_t k);
    case (k)
      DDRL_KIND_QUAD: mode_cnt = `DDRL_MODE_QUAD;
      DDRL_KIND_DUAL: mode_cnt = `DDRL_MODE_DUAL;
      default: mode_cnt = `DDRL_MODE_FAST;
    endcase
  endfunction : mode_cnt

  function automatic logic [7:0] lat_cnt(input ddrl_kind_t k, input logic [1:0] code);
    lat_cnt = 8'h00;
    case (code)
      2'b11: lat_cnt = (k == DDRL_KIND_QUAD) ? `DDRL_LAT_C11_QUAD :
                       (k == DDRL_KIND_DUAL) ? `DDRL_LAT_C11_DUAL : `DDRL_LAT_C11_FAST;
      2'b00: lat_cnt = (k == DDRL_KIND_QUAD) ? `DDRL_LAT_C00_QUAD :
                       (k == DDRL_KIND_DUAL) ? `DDRL_LAT_C00_DUAL : `DDRL_LAT_C00_FAST;
      2'b01: lat_cnt = (k == DDRL_KIND_QUAD) ? `DDRL_LAT_C01_QUAD :
                       (k == DDRL_KIND_DUAL) ? `DDRL_LAT_C01_DUAL : `DDRL_LAT_C01_FAST;
      default: lat_cnt = (k == DDRL_KIND_QUAD) ? `DDRL_LAT_C10_QUAD :
                         (k == DDRL_KIND_DUAL) ? `DDRL_LAT_C10_DUAL : `DDRL_LAT_C10_FAST;
    endcase
  endfunction : lat_cnt

  function automatic logic [7:0] fmax(input logic [1:0] code);
    case (code)
      2'b11: fmax = `DDRL_FMAX_C11;
      2'b00: fmax = `DDRL_FMAX_C00;
      2'b01: fmax = `DDRL_FMAX_C01;
      default: fmax = `DDRL_FMAX_C10;
    endcase
  endfunction : fmax

endpackage : ddrl_pkg

// [tb/ddrl_monitor.sv]
// ddrl_monitor: link-level checks of ddr read framing and query answers.
// assumes it sits beside the main link, fed its signals and the latency code.
`timescale 1ns/1ps

module ddrl_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] lat_code,
  input wire logic cs,
  input wire logic [7:0] host_dq,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic q_req,
  input wire logic [5:0] q_off,
  input wire logic q_ack,
  input wire logic [7:0] q_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // frame opening with a given opcode and latency code
  sequence frame_start(logic [7:0] o, logic [1:0] lc);
    $rose(cs) && host_dq == o && lat_code == lc;
  endsequence
  sequence quiet;
    !host_oe && !dev_oe;
  endsequence

  chk_query_ack: assert property (q_req |=> q_ack) else $error("no query answer");
  chk_query_idle: assert property (!q_req |=> !q_ack) else $error("stray query answer");
  chk_query_head: assert property (q_req && q_off == 6'h00 |=> q_data == 8'h9a)
    else $error("table id wrong");
  chk_row_shape: assert property (q_req && q_off inside {6'h02, 6'h03} |=>
    q_data == (($past(q_off) == 6'h02) ? 8'h05 : 8'h08)) else $error("row shape wrong");
  chk_fast_limit: assert property (q_req && q_off == 6'h0c |=> q_data == 8'h32)
    else $error("code 11 ceiling wrong");
  chk_slow_limit: assert property (q_req && q_off inside {6'h14, 6'h1c, 6'h24}
    |=> q_data == 8'h42) else $error("66 mhz ceiling wrong");
  chk_frame_opcode: assert property ($rose(cs) |-> host_oe &&
    host_dq inside {8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee}) else $error("bad opcode framed");
  chk_quad_timing: assert property (frame_start(8'hed, 2'b11) |->
    ##4 (host_oe && host_dq == 8'h00) ##1 quiet [*3] ##1 dev_oe) else $error("quad 11 timing");
  chk_fast_timing: assert property (frame_start(8'h0d, 2'b11) |->
    ##4 quiet [*4] ##1 dev_oe) else $error("fast 11 timing");
  chk_dual_timing: assert property (frame_start(8'hbe, 2'b00) |->
    ##5 quiet [*6] ##1 dev_oe) else $error("dual 00 timing");
  chk_dev_turn: assert property ($rose(dev_oe) |-> cs && !host_oe) else $error("dev drove early");
  chk_dev_release: assert property ($fell(cs) |-> ##[0:1] !dev_oe) else $error("dev held bus");
endmodule : ddrl_monitor

// [tb/testbench.sv]
// testbench: both link ends joined, reads over all codes, query table, faults.
// assumes the design files and ddrl_defs.svh are compiled first.
`timescale 1ns/1ps

module testbench;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
  logic core_clk = 1'b0, rstn = 1'b0, rd_start = 1'b0, q_start = 1'b0;
  logic [1:0] lat_code = 2'b11;
  logic [7:0] rd_op = 8'h0d, rd_len = 8'h01, rx_data, q_data, mem_data;
  logic [31:0] rd_addr = 32'h0, mem_addr;
  logic [5:0] q_off = 6'h00;
  logic busy, rx_valid, done, err, q_valid, frame_err, err2;
  int errors = 0, n_checks = 0, cyc = 0;
  logic [7:0] qexp [64];
  // row: code, ceiling, fast, dual, quad latency
  localparam logic [39:0] ROWS [4] = '{40'h03_32_04_04_03, 40'h00_42_05_06_06,
    40'h01_42_06_07_07, 40'h02_42_07_08_08};
  localparam logic [7:0] OPS [3] = '{8'h0d, 8'hbd, 8'hed};
  localparam logic [7:0] HDR [12] = '{8'h9a, 8'h2a, 8'h05, 8'h08, 8'h46, 8'h43,
    8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee};

  ddrl_if link ();
  ddrl_if link2 ();
  ddrl_if link3 ();
  ddrl_dev ddrl_dev_inst (.core_clk(core_clk), .rstn(rstn), .link(link), .lat_code(lat_code),
    .mem_addr(mem_addr), .mem_data(mem_data), .frame_err());
  ddrl_host ddrl_host_inst (.core_clk(core_clk), .rstn(rstn), .link(link), .lat_code(lat_code),
    .rd_start(rd_start), .rd_op(rd_op), .rd_addr(rd_addr), .rd_len(rd_len), .busy(busy),
    .rx_data(rx_data), .rx_valid(rx_valid), .done(done), .err(err), .q_start(q_start),
    .q_off(q_off), .q_data(q_data), .q_valid(q_valid));
  // second flash end faced by a bench driver that sends a bad opcode
  ddrl_dev ddrl_dev_inst2 (.core_clk(core_clk), .rstn(rstn), .link(link2), .lat_code(lat_code),
    .mem_addr(), .mem_data(8'h00), .frame_err(frame_err));
  // 64 mhz host: only code 11 is over its ceiling; no flash end behind it
  ddrl_host #(.SCK_MHZ(8'h40)) ddrl_host_inst2 (.core_clk(core_clk), .rstn(rstn), .link(link3),
    .lat_code(lat_code), .rd_start(rd_start), .rd_op(rd_op), .rd_addr(rd_addr), .rd_len(rd_len),
    .busy(), .rx_data(), .rx_valid(), .done(), .err(err2), .q_start(1'b0), .q_off(6'h00),
    .q_data(), .q_valid());
  ddrl_monitor ddrl_monitor_inst (.core_clk(core_clk), .rstn(rstn), .lat_code(lat_code),
    .cs(link.cs), .host_dq(link.host_dq), .host_oe(link.host_oe), .dev_oe(link.dev_oe),
    .q_req(link.q_req), .q_off(link.q_off), .q_ack(link.q_ack), .q_data(link.q_data));

  function automatic logic [7:0] memf(input logic [31:0] a);
    memf = a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : memf
  // memory is a pure function of the address, so every byte is predictable
  assign mem_data = memf(mem_addr);

  always #5 core_clk = ~core_clk;

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // hang guard, far above the several hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic start(input logic [7:0] op, input logic [31:0] ad, input logic [7:0] len);
    // one edge first, so back-to-back starts never raise rd_start as it drops
    @(posedge core_clk);
    #1 rd_op = op;
    rd_addr = ad;
    rd_len = len;
    rd_start = 1'b1;
    @(posedge core_clk);
    #1 rd_start = 1'b0;
  endtask : start

  task automatic do_read(input logic [7:0] op, input logic [31:0] ad, input int m, input int l,
                         input bit poke);
    int c;
    int a;
    logic [31:0] eff;
    a = op[0] ? 3 : 4;
    eff = op[0] ? {8'h00, ad[23:0]} : ad;
    c = 0;
    start(op, ad, 8'h03);
    `CHK("err2", lat_code == 2'b11, err2)
    `CHK("op", op, link.dq_bus)
    while (rx_valid !== 1'b1 && c < 40) begin
      @(posedge core_clk);
      #1 c++;
      rd_start = poke && c == 2; // a start while busy must be ignored
      if (c <= a)
        `CHK("addr", eff[8*(a-c) +: 8], link.dq_bus)
      else if (c <= a + m)
        `CHK("mode", 8'h00, link.dq_bus)
      else if (c <= a + m + l)
        `CHK("idle", 2'b00, {link.host_oe, link.dev_oe})
    end
    `CHK("first", 2 + a + m + l, c)
    for (int i = 0; i < 3; i++) begin
      if (i > 0) begin
        @(posedge core_clk);
        #1;
      end
      `CHK("byte", {1'b1, i == 2, memf(eff + i)}, {rx_valid, done, rx_data})
    end
    @(posedge core_clk);
    #1 `CHK("busy", 1'b0, busy)
  endtask : do_read

  initial begin
    for (int i = 0; i < 64; i++) qexp[i] = (i < 12) ? HDR[i] : 8'h00;
    for (int r = 0; r < 4; r++) begin
      qexp[12+8*r] = ROWS[r][31:24];
      qexp[13+8*r] = ROWS[r][39:32];
      qexp[15+8*r] = ROWS[r][23:16];
      qexp[17+8*r] = ROWS[r][15:8];
      qexp[18+8*r] = 8'h01;
      qexp[19+8*r] = ROWS[r][7:0];
    end
    link2.cs = 1'b0;
    link2.host_oe = 1'b0;
    link2.host_dq = 8'h00;
    link2.q_req = 1'b0;
    link2.q_off = 6'h00;
    // the lone host sees a silent flash end
    link3.dev_dq = 8'h00;
    link3.dev_oe = 1'b0;
    link3.q_ack = 1'b0;
    link3.q_data = 8'h00;
    repeat (6) @(posedge core_clk);
    #1 `CHK("rst", 35'h0, {busy, link.cs, link.dev_oe, mem_addr})
    rstn = 1'b1;
    // every code, kind and address width; reads of both forms carry from fe past ff
    for (int r = 0; r < 4; r++)
      for (int k = 0; k < 3; k++)
        for (int w = 0; w < 2; w++) begin
          lat_code = ROWS[r][33:32];
          do_read(OPS[k] + 8'(w), 32'h1234_56fe, (k == 2) ? 1 : 0,
                  int'(ROWS[r][8*(2-k) +: 8]), r == 0 && k == 0);
        end
    // query table read back to back, one past the end as well
    for (int k = 0; k <= 8'h2c + 3; k++) begin
      q_start = k <= 8'h2c;
      q_off = 6'(k);
      if (k >= 3)
        `CHK("query", {1'b1, qexp[k-3]}, {q_valid, q_data})
      @(posedge core_clk);
      #1;
    end
    q_start = 1'b0;
    // refused starts: unknown opcode and zero length
    start(8'h0b, 32'h0, 8'h01);
    `CHK("bad op", 2'b10, {err, busy})
    start(8'h0d, 32'h0, 8'h00);
    `CHK("zero len", 2'b10, {err, busy})
    // reset in mid-frame, then a clean read
    lat_code = 2'b00;
    start(8'hed, 32'h40, 8'h03);
    repeat (5) @(posedge core_clk);
    #1 rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 `CHK("mid rst", 3'b000, {link.cs, link.dev_oe, busy})
    rstn = 1'b1;
    do_read(8'hed, 32'h40, 1, 6, 1'b0);
    // flash end facing an unknown opcode stays off the bus
    link2.cs = 1'b1;
    link2.host_oe = 1'b1;
    link2.host_dq = 8'h0b;
    begin
      int fe;
      int oe;
      fe = 0;
      oe = 0;
      for (int i = 0; i < 12; i++) begin
        @(posedge core_clk);
        #1 link2.host_dq = 8'h00;
        fe += int'(frame_err === 1'b1);
        oe += int'(link2.dev_oe !== 1'b0);
        if (i == 8) link2.cs = 1'b0;
      end
      `CHK("frame err", 2, {fe, oe} == {32'd1, 32'd0} ? 2 : 0)
    end
    print_verdict();
  end
endmodule : testbench
